// File: design/thermo_map.svh
/*
 * Offsets, reset values, command codes and timing figures of the
 * temperature conversion block.
 * Assumes it is included by bare name; holds definitions only.
 */
`ifndef THERMO_MAP_SVH
`define THERMO_MAP_SVH

// ----------------------------------------------------------------
// commands
// ----------------------------------------------------------------
`define CMD_CONVERT 8'h44

// ----------------------------------------------------------------
// scratchpad byte offsets
// ----------------------------------------------------------------
`define SP_TEMP_LSB 4'h0
`define SP_TEMP_MSB 4'h1
`define SP_ALARM_HI 4'h2
`define SP_ALARM_LO 4'h3
`define SP_RSVD_A 4'h4
`define SP_RSVD_B 4'h5
`define SP_REMAIN 4'h6
`define SP_PER_DEG 4'h7
`define SP_CRC 4'h8

// ----------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------
`define TEMP_BITS 9
`define TEMP_SIGN_BIT 8
`define TEMP_RESET 16'h00AA
`define REMAIN_RESET 8'h00
`define COUNTS_PER_DEGREE 8'h10
`define RESERVED_BYTE 8'hFF
`define CRC_FILL 8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CONV_TIME_MS 750
`define CLK_MHZ 100

`endif

// File: design/thermo_pkg.sv
/*
 * Types of the temperature conversion block.
 * Assumes nothing of its surroundings.
 */
package thermo_pkg;

   // gray along idle -> convert -> store; store -> idle flips both bits
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONV = 2'b01,
      ST_STORE = 2'b11
   } conv_state_type;

endpackage : thermo_pkg

// File: design/conv_timer.sv
/*
 * Conversion timer: one done pulse a fixed number of cycles after start.
 * Assumes start is a one-cycle pulse on clk, rst synchronous high.
 */
`timescale 1ns/100ps
module conv_timer #(
   parameter int CYCLES = 75000000
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   output logic running,
   output logic done
);
   logic [31:0] cnt_q;
   logic run_q;
   logic done_q;
   wire logic at_end = (cnt_q == 32'h0);

   always_ff @(posedge clk) begin
      if (rst) begin
         run_q <= 1'b0;
         cnt_q <= 32'h0;
         done_q <= 1'b0;
      end else begin
         done_q <= run_q & at_end;
         if (start) begin
            run_q <= 1'b1;
            cnt_q <= 32'(CYCLES - 1);
         end else if (run_q) begin
            run_q <= ~at_end;
            cnt_q <= at_end ? cnt_q : cnt_q - 32'h1;
         end
      end
   end

   assign running = run_q;
   assign done = done_q;
endmodule : conv_timer

// File: design/temp_format.sv
/*
 * Formats a raw half-degree sample into the sign-extended result word.
 * Assumes the sample is two's complement, LSB worth half a degree.
 */
`timescale 1ns/100ps
`include "thermo_map.svh"
module temp_format (
   input wire logic [`TEMP_BITS-1:0] sample,
   output logic [15:0] word
);
   genvar i;
   // every upper bit repeats the sign
   generate
      for (i = 0; i < 16; i++) begin : g_bit
         if (i < `TEMP_SIGN_BIT) begin : g_mag
            assign word[i] = sample[i];
         end else begin : g_sign
            assign word[i] = sample[`TEMP_SIGN_BIT];
         end
      end
   endgenerate
endmodule : temp_format

// File: design/temp_conversion_result.sv
/*
 * Temperature conversion control and result formatting for a
 * single-wire-bus thermometer: command start, progress answers in
 * read slots on external power, scratchpad byte view of the result.
 * Assumes slot timing and the command layer decode sit outside and hand
 * over one-cycle strobes on clk; the supply sense pin is asynchronous.
 */
`timescale 1ns/100ps
`include "thermo_map.svh"
module temp_conversion_result
   import thermo_pkg::*;
#(
   parameter int CONV_CYCLES = `CONV_TIME_MS * 1000 * `CLK_MHZ,
   // arbitrary identity value
   parameter logic [63:0] ROM_CODE = 64'h5A3C_96E1_0B7D_4F28
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic match_valid,
   input wire logic [63:0] match_code,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic read_slot,
   input wire logic supply_pin,
   input wire logic [`TEMP_BITS-1:0] sensor_code,
   input wire logic [7:0] sensor_remain,
   input wire logic [7:0] alarm_hi_nv,
   input wire logic [7:0] alarm_lo_nv,
   input wire logic [3:0] scratch_addr,
   output logic [7:0] scratch_rdata,
   output logic [15:0] temp_result,
   output logic busy,
   output logic conv_done,
   output logic selected,
   output logic dq_out,
   output logic dq_oe
);

   // ----------------------------------------------------------------
   // supply sense synchroniser
   // ----------------------------------------------------------------
   logic sup1_q;
   logic sup2_q;
   logic sup3_q;
   logic ext_power_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         sup1_q <= 1'b0;
         sup2_q <= 1'b0;
         sup3_q <= 1'b0;
         ext_power_q <= 1'b0;
      end else begin
         sup1_q <= supply_pin;
         sup2_q <= sup1_q;
         sup3_q <= sup2_q;
         if (sup2_q == sup3_q) begin
            ext_power_q <= sup2_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // device selection and command decode
   // ----------------------------------------------------------------
   logic selected_q;
   logic armed_q;
   conv_state_type state_q;
   conv_state_type state_d;

   wire logic code_hit = (match_code == ROM_CODE);
   wire logic cmd_take = cmd_valid & selected_q;
   wire logic is_convert = (cmd_code == `CMD_CONVERT);
   wire logic start_conv = cmd_take & is_convert & (state_q == ST_IDLE);

   always_ff @(posedge clk) begin
      if (rst) begin
         selected_q <= 1'b0;
      end else if (match_valid) begin
         selected_q <= code_hit;
      end
   end

   // polling stays armed from a convert command until another command
   always_ff @(posedge clk) begin
      if (rst) begin
         armed_q <= 1'b0;
      end else if (cmd_take) begin
         armed_q <= is_convert;
      end
   end

   // ----------------------------------------------------------------
   // conversion sequencing
   // ----------------------------------------------------------------
   logic timer_running;
   logic timer_done;

   conv_timer #(
      .CYCLES(CONV_CYCLES)
   ) u_timer (
      .clk(clk),
      .rst(rst),
      .start(start_conv),
      .running(timer_running),
      .done(timer_done)
   );

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (start_conv) begin
               state_d = ST_CONV;
            end
         end
         ST_CONV: begin
            if (timer_done) begin
               state_d = ST_STORE;
            end
         end
         ST_STORE: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   logic busy_q;
   logic done_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         busy_q <= (state_d != ST_IDLE);
         done_q <= (state_q == ST_STORE);
      end
   end

   // ----------------------------------------------------------------
   // result registers
   // ----------------------------------------------------------------
   logic [15:0] fmt_word;
   logic [15:0] temp_q;
   logic [7:0] remain_q;

   temp_format u_format (
      .sample(sensor_code),
      .word(fmt_word)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         temp_q <= `TEMP_RESET;
         remain_q <= `REMAIN_RESET;
      end else if (state_q == ST_STORE) begin
         temp_q <= fmt_word;
         remain_q <= sensor_remain;
      end
   end

   // ----------------------------------------------------------------
   // scratchpad byte view
   // ----------------------------------------------------------------
   logic [7:0] byte_sel;
   logic [7:0] rdata_q;

   always_comb begin
      case (scratch_addr)
         `SP_TEMP_LSB: byte_sel = temp_q[7:0];
         `SP_TEMP_MSB: byte_sel = temp_q[15:8];
         `SP_ALARM_HI: byte_sel = alarm_hi_nv;
         `SP_ALARM_LO: byte_sel = alarm_lo_nv;
         `SP_RSVD_A: byte_sel = `RESERVED_BYTE;
         `SP_RSVD_B: byte_sel = `RESERVED_BYTE;
         `SP_REMAIN: byte_sel = remain_q;
         `SP_PER_DEG: byte_sel = `COUNTS_PER_DEGREE;
         `SP_CRC: byte_sel = `CRC_FILL;
         default: byte_sel = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= byte_sel;
      end
   end

   // ----------------------------------------------------------------
   // progress answer on the data line
   // ----------------------------------------------------------------
   logic oe_q;
   logic out_q;

   // a zero bit pulls low; a one bit leaves the line to the pullup
   wire logic slot_low = read_slot & armed_q & ext_power_q & busy_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         oe_q <= 1'b0;
         out_q <= 1'b0;
      end else begin
         oe_q <= slot_low;
         out_q <= 1'b0;
      end
   end

   assign scratch_rdata = rdata_q;
   assign temp_result = temp_q;
   assign busy = busy_q;
   assign conv_done = done_q;
   assign selected = selected_q;
   assign dq_out = out_q;
   assign dq_oe = oe_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [31:0] busy_cnt_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         busy_cnt_q <= 32'h0;
      end else begin
         busy_cnt_q <= busy_q ? busy_cnt_q + 32'h1 : 32'h0;
      end
   end

   start_on_cmd_a: assert property (@(posedge clk) disable iff (rst)
      (state_q == ST_IDLE) && cmd_valid && selected_q && (cmd_code == `CMD_CONVERT)
      |=> busy_q && (state_q == ST_CONV))
      else $error("convert command did not start a conversion");

   idle_stays_a: assert property (@(posedge clk) disable iff (rst)
      (state_q == ST_IDLE) && !start_conv |=> !busy_q)
      else $error("left idle without a convert command");

   result_stored_a: assert property (@(posedge clk) disable iff (rst)
      timer_done && (state_q == ST_CONV)
      ##1 1'b1 |=> (temp_q == {{7{$past(sensor_code[8])}}, $past(sensor_code)})
      ##1 (state_q == ST_IDLE))
      else $error("result not stored or no return to idle");

   sign_repeat_a: assert property (@(posedge clk) disable iff (rst)
      temp_q[15:8] == {8{temp_q[7] ^ temp_q[7] ^ temp_q[8]}})
      else $error("upper result bits do not all repeat the sign");

   half_degree_a: assert property (@(posedge clk) disable iff (rst)
      (state_q == ST_STORE) |=> temp_q[0] == $past(sensor_code[0]))
      else $error("result lsb is not the half degree bit");

   reset_value_a: assert property (@(posedge clk)
      $past(rst) && !rst |-> temp_q == `TEMP_RESET)
      else $error("result register did not reset to 00AA");

   per_degree_a: assert property (@(posedge clk) disable iff (rst)
      scratch_addr == `SP_PER_DEG |=> scratch_rdata == 8'h10)
      else $error("counts per degree byte is not 16");

   temp_bytes_a: assert property (@(posedge clk) disable iff (rst)
      scratch_addr == `SP_TEMP_MSB |=> scratch_rdata == $past(temp_q[15:8]))
      else $error("byte 1 does not show the result high byte");

   alarm_bytes_a: assert property (@(posedge clk) disable iff (rst)
      scratch_addr == `SP_ALARM_LO |=> scratch_rdata == $past(alarm_lo_nv))
      else $error("byte 3 does not show the low alarm limit");

   poll_busy_a: assert property (@(posedge clk) disable iff (rst)
      read_slot && armed_q && ext_power_q && busy_q |=> dq_oe ##1 !dq_oe)
      else $error("busy read slot not answered with a single low");

   poll_done_a: assert property (@(posedge clk) disable iff (rst)
      read_slot && !busy_q |=> !dq_oe)
      else $error("finished conversion answered with a low");

   open_drain_a: assert property (@(posedge clk) disable iff (rst)
      !dq_out)
      else $error("data line driven high");

   conv_bound_a: assert property (@(posedge clk) disable iff (rst)
      busy_q |-> busy_cnt_q <= 32'(CONV_CYCLES + 2))
      else $error("conversion exceeded its maximum time");

   select_code_a: assert property (@(posedge clk) disable iff (rst)
      match_valid |=> selected_q == $past(match_code == ROM_CODE))
      else $error("selection does not follow the rom code match");

   timer_pair_a: assert property (@(posedge clk) disable iff (rst)
      (state_q == ST_CONV) |-> timer_running || timer_done)
      else $error("converting with the timer stopped");

endmodule : temp_conversion_result

// File: dv/bus_master_model.sv
/*
 * Bus master model: selects the device, sends function commands and
 * issues read slots, one clk cycle per strobe.
 * Assumes slot timing lives outside the block and strobes are sampled
 * on the rising edge of clk.
 */
`timescale 1ns/100ps
module bus_master_model (
   input wire logic clk,
   input wire logic dq,
   output logic match_valid,
   output logic [63:0] match_code,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic read_slot
);
   // ------------------------------------------------------------
   // idle levels
   // ------------------------------------------------------------
   initial begin
      match_valid = 1'b0;
      match_code = 64'h0;
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      read_slot = 1'b0;
   end

   // ------------------------------------------------------------
   // transfers
   // ------------------------------------------------------------
   // whole 64-bit code per selection
   task automatic select(input logic [63:0] code);
      @(negedge clk);
      match_valid = 1'b1;
      match_code = code;
      @(negedge clk);
      match_valid = 1'b0;
      match_code = ~code;
   endtask : select

   task automatic command(input logic [7:0] code);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_code = code;
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd_code = ~code;
   endtask : command

   // only called with an externally powered device
   task automatic poll(output logic bit_val);
      @(negedge clk);
      read_slot = 1'b1;
      @(negedge clk);
      read_slot = 1'b0;
      bit_val = dq;
   endtask : poll
endmodule : bus_master_model

// File: dv/temp_conversion_result_tb.sv
/*
 * Testbench of the temperature conversion block: reset values,
 * selection, command start, progress answers and result formatting.
 * Assumes the bus master model drives all strobes at falling edges.
 */
`timescale 1ns/100ps
`include "thermo_map.svh"
module temp_conversion_result_tb;
   localparam int CONV = 20;
   // arbitrary selection value
   localparam logic [63:0] DEV_CODE = 64'hC3A5_1E2D_7788_9B04;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic supply_pin = 1'b1;
   logic [8:0] sensor_code = 9'h000;
   logic [7:0] sensor_remain = 8'h0C;
   logic [7:0] alarm_hi = 8'h4B;
   logic [7:0] alarm_lo = 8'hF6;
   logic [3:0] scratch_addr = 4'h0;
   logic match_valid, cmd_valid, read_slot, busy, conv_done, selected, dq_out, dq_oe, dq;
   logic [63:0] match_code;
   logic [7:0] cmd_code, scratch_rdata;
   logic [15:0] temp_result;
   logic [8:0] samples [4] = '{9'h032, 9'h1FF, 9'h192, 9'h001};
   int mismatches = 0;
   int checks_done = 0;
   int ext16;
   logic poll_bit;

   always #5 clk = ~clk;
   // weak pullup unless the device pulls low
   assign dq = (dq_oe && !dq_out) ? 1'b0 : 1'b1;

   temp_conversion_result #(.CONV_CYCLES(CONV), .ROM_CODE(DEV_CODE)) temp_conversion_result_i (
      .clk(clk), .rst(rst), .match_valid(match_valid), .match_code(match_code),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .read_slot(read_slot),
      .supply_pin(supply_pin), .sensor_code(sensor_code), .sensor_remain(sensor_remain),
      .alarm_hi_nv(alarm_hi), .alarm_lo_nv(alarm_lo), .scratch_addr(scratch_addr),
      .scratch_rdata(scratch_rdata), .temp_result(temp_result), .busy(busy),
      .conv_done(conv_done), .selected(selected), .dq_out(dq_out), .dq_oe(dq_oe));

   bus_master_model bus_master_model_i (
      .clk(clk), .dq(dq), .match_valid(match_valid), .match_code(match_code),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .read_slot(read_slot));

   // ------------------------------------------------------------
   // checking tasks
   // ------------------------------------------------------------
   task automatic summarize;
      $display("mismatches %0d checks_done %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : cmp

   task automatic rd_byte(input logic [3:0] a, input logic [7:0] exp);
      @(negedge clk);
      scratch_addr = a;
      @(negedge clk);
      cmp({8'h00, scratch_rdata}, {8'h00, exp}, "scratch byte");
   endtask : rd_byte

   // one conversion; polls and retries the command only on external power
   task automatic convert(input logic [8:0] s, input logic ext);
      int n;
      logic b;
      sensor_code = s;
      n = 1;
      bus_master_model_i.command(`CMD_CONVERT);
      if (ext) begin
         bus_master_model_i.poll(b);
         cmp({15'h0, b}, 16'h0000, "busy answer");
         // repeated start while busy is ignored, timer keeps its count
         bus_master_model_i.command(`CMD_CONVERT);
         n = 5;
      end
      while (conv_done !== 1'b1 && n < 4 * CONV) begin
         @(negedge clk);
         n++;
      end
      if (n >= 4 * CONV) begin
         mismatches++;
         summarize();
      end
      cmp({15'h0, n <= CONV + 4}, 16'h0001, "conversion time");
      cmp({15'h0, busy}, 16'h0000, "idle after store");
      cmp(temp_result, {{7{s[8]}}, s}, "result word");
      if (ext) begin
         bus_master_model_i.poll(b);
         cmp({15'h0, b}, 16'h0001, "done answer");
      end
   endtask : convert

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      cmp(temp_result, `TEMP_RESET, "reset result");
      rd_byte(`SP_TEMP_LSB, 8'hAA);
      rd_byte(`SP_TEMP_MSB, 8'h00);
      rd_byte(`SP_PER_DEG, `COUNTS_PER_DEGREE);
      rd_byte(`SP_ALARM_HI, alarm_hi);
      rd_byte(`SP_ALARM_LO, alarm_lo);
      rd_byte(`SP_RSVD_A, `RESERVED_BYTE);
      bus_master_model_i.command(`CMD_CONVERT);
      repeat (3) @(negedge clk);
      cmp({15'h0, busy}, 16'h0000, "start while unselected");
      bus_master_model_i.select(~DEV_CODE);
      cmp({15'h0, selected}, 16'h0000, "foreign code");
      bus_master_model_i.select(DEV_CODE);
      cmp({15'h0, selected}, 16'h0001, "own code");
      bus_master_model_i.command(8'hBE);
      repeat (3) @(negedge clk);
      cmp({15'h0, busy}, 16'h0000, "other command");
      foreach (samples[i]) begin
         convert(samples[i], 1'b1);
      end
      // a later command disarms the progress answer; the line stays released
      sensor_code = 9'h000;
      bus_master_model_i.command(`CMD_CONVERT);
      bus_master_model_i.command(8'hBE);
      bus_master_model_i.poll(poll_bit);
      cmp({15'h0, poll_bit}, 16'h0001, "disarmed answer");
      cmp({15'h0, busy}, 16'h0001, "still converting");
      repeat (2 * CONV) @(negedge clk);
      cmp({15'h0, busy}, 16'h0000, "idle after disarmed run");
      cmp(temp_result, 16'h0000, "result after disarm");
      supply_pin = 1'b0;
      repeat (6) @(negedge clk);
      // master holds strong pullup instead of polling
      convert(9'h1CE, 1'b0);
      rd_byte(`SP_TEMP_MSB, 8'hFF);
      rd_byte(`SP_TEMP_LSB, 8'hCE);
      rd_byte(`SP_REMAIN, sensor_remain);
      // master's extended reading in sixteenths of a degree: -25.0 C here
      ext16 = ($signed(temp_result) >>> 1) * 16 - 4;
      ext16 = ext16 + int'(`COUNTS_PER_DEGREE) - int'(scratch_rdata);
      cmp(16'(ext16), 16'hFE70, "extended reading");
      summarize();
   end
endmodule : temp_conversion_result_tb
